// >>> bench/fasr_host.sv
`timescale 1ns/1ps
// ==========================================================
// Host controller model driving the register strobes.
module fasr_host (
  input  wire logic          mclk_i,
  output fasr_pkg::fasr_wr_t wr_o,
  output logic               rd_en_o,
  output logic [7:0]         rd_addr_o,
  input  wire logic [15:0]   rd_data_i
);
  // Idle bus at time zero.
  initial begin
    wr_o = '0;
    rd_en_o = 1'b0;
    rd_addr_o = 8'h00;
  end

  // Zero bits acknowledge faults; stale fields are inverted on release.
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge mclk_i);
    #1 wr_o = '{1'b1, a, d};
    @(posedge mclk_i);
    #1 wr_o = '{1'b0, ~a, ~d};
  endtask : wr

  // Data is taken once the read edge has updated the output.
  task automatic rd(logic [7:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    #1 rd_en_o = 1'b1;
    rd_addr_o = a;
    @(posedge mclk_i);
    #1 rd_en_o = 1'b0;
    rd_addr_o = ~a;
    d = rd_data_i;
  endtask : rd
endmodule : fasr_host

// >>> bench/fasr_regs_props.sv
`timescale 1ns/1ps
// ==========================================================
// Checker on the register block ports.
module fasr_regs_props (
  input wire logic                  mclk_i,
  input wire logic                  rst_n_i,
  input wire logic                  osc_lf_i,
  input wire fasr_pkg::fasr_cond_t  cond_i,
  input wire fasr_pkg::fasr_alert_t alert_i,
  input wire fasr_pkg::fasr_wr_t    wr_i,
  input wire logic                  rd_en_i,
  input wire logic [7:0]            rd_addr_i,
  input wire logic [15:0]           rd_data_o,
  input wire logic                  rd_valid_o,
  input wire logic                  por_flag_o,
  input wire logic                  fault_summary_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // A read taken at this edge for the given register.
  sequence s_rd(logic [7:0] a);
    rd_en_i && rd_addr_i == a;
  endsequence

  a_cell_or_view: assert property (
    s_rd(fasr_pkg::CELL_OFS) |=>
    rd_data_o == {2'h0, $past(alert_i.aux_ov | alert_i.aux_uv),
    $past(alert_i.cell_ov | alert_i.cell_uv)})
    else $error("cell alert read wrong");
  a_fault_zero: assert property (s_rd(fasr_pkg::FAULT_OFS) |=>
    !rd_data_o[13]) else $error("fault bit 13 not zero");
  a_balsw_live: assert property (s_rd(fasr_pkg::FAULT_OFS) |=>
    rd_data_o[5] == |$past(alert_i.balsw)) else $error("bit 5 wrong");
  a_osc_pair: assert property (s_rd(fasr_pkg::FAULT_OFS) |=>
    rd_data_o[15] == rd_data_o[14]) else $error("osc flags differ");
  a_gated_por: assert property (s_rd(fasr_pkg::FAULT_OFS) ##0
    por_flag_o |=> (rd_data_o & 16'h19cf) == 16'h0000)
    else $error("gated flag set under power-on flag");
  a_se_redundant: assert property (s_rd(fasr_pkg::FAULT_OFS) |=>
    (rd_data_o[10:9] & $past({cond_i.upper_se, cond_i.lower_se}, 2))
    == $past({cond_i.upper_se, cond_i.lower_se}, 2))
    else $error("redundant single-ended flag missing");
  a_por_clear: assert property (wr_i.en && !wr_i.data[15] &&
    wr_i.addr == fasr_pkg::STATUS_OFS |=> !por_flag_o)
    else $error("power-on flag not cleared");
  a_por_stays: assert property (!por_flag_o |=> !por_flag_o)
    else $error("power-on flag set again");
  a_summary_or: assert property (s_rd(fasr_pkg::FAULT_OFS) |=>
    fault_summary_o == |rd_data_o) else $error("summary wrong");
endmodule : fasr_regs_props

bind fasr_regs fasr_regs_props u_props (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .osc_lf_i(osc_lf_i),
  .cond_i(cond_i), .alert_i(alert_i), .wr_i(wr_i), .rd_en_i(rd_en_i),
  .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .por_flag_o(por_flag_o), .fault_summary_o(fault_summary_o));

// >>> bench/fasr_regs_tb.sv
`timescale 1ns/1ps
module fasr_regs_tb;
  // ==========================================================
  // Signals
  logic                  mclk_i = 1'b0;
  logic                  rst_n_i = 1'b0;
  logic                  osc_lf_i = 1'b0;
  logic                  osc_run = 1'b1;
  int                    osc_half = 25;
  fasr_pkg::fasr_cond_t  cond_i = '0;
  fasr_pkg::fasr_alert_t alert_i = '0;
  fasr_pkg::fasr_wr_t    wr_i;
  logic                  rd_en_i;
  logic [7:0]            rd_addr_i;
  logic [15:0]           rd_data_o;
  logic                  rd_valid_o;
  logic                  por_flag_o;
  logic                  fault_summary_o;
  logic [15:0]           v;
  int                    fails = 0;
  int                    tests_run = 0;
  typedef struct packed {
    fasr_pkg::fasr_alert_t a;
    logic [15:0]           e;
  } fasr_row_t;
  localparam fasr_row_t ROWS [4] = '{
    '{'{12'h080, 12'h001, 12'h800, 2'h1, 2'h0}, 16'h1801},
    '{'{12'h000, 12'h000, 12'h000, 2'h0, 2'h2}, 16'h2000},
    '{'{12'hfff, 12'h555, 12'haaa, 2'h3, 2'h3}, 16'h3fff},
    '{'{12'h000, 12'h000, 12'h000, 2'h0, 2'h0}, 16'h0000}};

  // ==========================================================
  // Clocks and instances
  always #2.5 mclk_i = ~mclk_i;
  // Slow oscillator; stopping or speeding it shows a bad oscillator.
  always begin
    repeat (osc_half) @(posedge mclk_i);
    #1 if (osc_run) osc_lf_i = ~osc_lf_i;
  end
  // Short counts keep the oscillator and settle checks quick.
  fasr_regs #(.OSC_LO_CYC(95), .OSC_HI_CYC(105), .SETTLE_CYC(20)) dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .osc_lf_i(osc_lf_i),
    .cond_i(cond_i), .alert_i(alert_i), .wr_i(wr_i), .rd_en_i(rd_en_i),
    .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .por_flag_o(por_flag_o), .fault_summary_o(fault_summary_o));
  fasr_host u_host (.mclk_i(mclk_i), .wr_o(wr_i), .rd_en_o(rd_en_i),
    .rd_addr_o(rd_addr_i), .rd_data_i(rd_data_o));

  // ==========================================================
  // Tasks
  task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, exp, got);
    end
  endtask : chk
  task automatic rc(string n, logic [7:0] a, logic [15:0] e);
    u_host.rd(a, v);
    chk(n, v, e);
    chk({n, " valid"}, {15'h0, rd_valid_o}, 16'h0001);
  endtask : rc
  // Start and done pulses spaced by gap cycles.
  task automatic diag(int gap);
    cond_i.diag_start = 1'b1;
    @(posedge mclk_i);
    #1 cond_i.diag_start = 1'b0;
    repeat (gap) @(posedge mclk_i);
    #1 cond_i.diag_done = 1'b1;
    @(posedge mclk_i);
    #1 cond_i.diag_done = 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask : diag
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // ==========================================================
  // Watchdog, well beyond the roughly 1300 cycles the tests need.
  initial begin
    #30000;
    fails++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    repeat (3) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    rc("fault rst", fasr_pkg::FAULT_OFS, 16'h0000);
    chk("por rst", {15'h0, por_flag_o}, 16'h0001);
    chk("sum rst", {15'h0, fault_summary_o}, 16'h0000);
    $display("test reset done");
    foreach (ROWS[i]) begin
      alert_i = ROWS[i].a;
      rc("cell", fasr_pkg::CELL_OFS, ROWS[i].e);
    end
    alert_i = '0;
    $display("test rows done");
    repeat (250) @(posedge mclk_i);
    u_host.wr(fasr_pkg::FAULT_OFS, 16'h0000);
    cond_i = 12'hffc;
    rc("gated", fasr_pkg::FAULT_OFS, 16'h0610);
    u_host.wr(fasr_pkg::STATUS_OFS, 16'h0000);
    chk("por clr", {15'h0, por_flag_o}, 16'h0000);
    rc("set", fasr_pkg::FAULT_OFS, 16'h1fdf);
    cond_i = '0;
    u_host.wr(fasr_pkg::FAULT_OFS, 16'hffff);
    rc("w1", fasr_pkg::FAULT_OFS, 16'h1fdf);
    cond_i.ground_open = 3'h1;
    u_host.wr(fasr_pkg::FAULT_OFS, 16'h0000);
    cond_i = '0;
    rc("set wins", fasr_pkg::FAULT_OFS, 16'h1e01);
    u_host.wr(fasr_pkg::FAULT_OFS, 16'hfffe);
    rc("w0", fasr_pkg::FAULT_OFS, 16'h1e00);
    $display("test latch done");
    diag(5);
    rc("short", fasr_pkg::FAULT_OFS, 16'h1e10);
    u_host.wr(fasr_pkg::FAULT_OFS, 16'h0000);
    diag(30);
    rc("settled", fasr_pkg::FAULT_OFS, 16'h1e00);
    $display("test settle done");
    osc_run = 1'b0;
    repeat (150) @(posedge mclk_i);
    rc("osc stop", fasr_pkg::FAULT_OFS, 16'hde00);
    osc_run = 1'b1;
    repeat (300) @(posedge mclk_i);
    u_host.wr(fasr_pkg::FAULT_OFS, 16'h0000);
    repeat (300) @(posedge mclk_i);
    rc("osc ok", fasr_pkg::FAULT_OFS, 16'h1e00);
    osc_half = 10;
    repeat (200) @(posedge mclk_i);
    rc("osc fast", fasr_pkg::FAULT_OFS, 16'hde00);
    $display("test osc done");
    alert_i.balsw = 12'h004;
    rc("balsw", fasr_pkg::FAULT_OFS, 16'hde20);
    chk("summary", {15'h0, fault_summary_o}, 16'h0001);
    alert_i.balsw = 12'h000;
    rc("unmapped", 8'h10, 16'h0000);
    u_host.wr(fasr_pkg::CELL_OFS, 16'hffff);
    rc("cell ro", fasr_pkg::CELL_OFS, 16'h0000);
    $display("test access done");
    wrap_up();
  end
endmodule : fasr_regs_tb

// >>> logic/fasr_regs.sv
`timescale 1ns/1ps

module fasr_regs #(
  parameter int OSC_LO_CYC = fasr_pkg::OSC_LO_CYC,
  parameter int OSC_HI_CYC = fasr_pkg::OSC_HI_CYC,
  parameter int SETTLE_CYC = fasr_pkg::SETTLE_CYC
) (
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  input  wire logic               osc_lf_i,
  input  wire fasr_pkg::fasr_cond_t  cond_i,
  input  wire fasr_pkg::fasr_alert_t alert_i,
  input  wire fasr_pkg::fasr_wr_t    wr_i,
  input  wire logic               rd_en_i,
  input  wire logic [7:0]         rd_addr_i,
  output logic [15:0]             rd_data_o,
  output logic                    rd_valid_o,
  output logic                    por_flag_o,
  output logic                    fault_summary_o
);

  localparam int CW = $clog2(OSC_HI_CYC + 2);
  localparam int SW = $clog2(SETTLE_CYC + 2);
  localparam logic [CW-1:0] LO_LIM = CW'(OSC_LO_CYC);
  localparam logic [CW-1:0] HI_LIM = CW'(OSC_HI_CYC);
  localparam logic [SW-1:0] ST_LIM = SW'(SETTLE_CYC);

  typedef enum logic [1:0] {
    OSC_SYNC,
    OSC_ONE,
    OSC_TWO
  } fasr_osc_t;

  typedef enum logic {
    DG_IDLE,
    DG_RUN
  } fasr_diag_t;

  // ==========================================================
  // Address decode

  // One compare shared by the write and read paths.
  function automatic logic fasr_hit(input logic [7:0] a,
                                    input logic [7:0] ofs);
    fasr_hit = (a == ofs);
  endfunction : fasr_hit

  logic        wr_fault;
  logic        wr_status;
  logic [15:0] clr_vec;

  // Zero bits of a write to the fault register clear latched bits.
  assign wr_fault  = wr_i.en & fasr_hit(wr_i.addr, fasr_pkg::FAULT_OFS);
  assign wr_status = wr_i.en & fasr_hit(wr_i.addr, fasr_pkg::STATUS_OFS);
  assign clr_vec   = wr_fault ? (~wr_i.data & fasr_pkg::FAULT_W0C_MASK)
                              : 16'h0000;

  // ==========================================================
  // Slow oscillator frequency check

  fasr_osc_t     osc_state_reg;
  logic [CW-1:0] osc_cnt_reg;
  logic          lf_prev_reg;
  logic          osc_fail_reg;
  logic          lf_rise;
  logic          osc_late;

  assign lf_rise  = osc_lf_i & ~lf_prev_reg;
  assign osc_late = (osc_cnt_reg >= HI_LIM);

  // Edge history of the slow clock, sampled as a plain input.
  // It leaves reset as if the input were high: a release while the
  // slow clock is high must not look like a rising edge, or the
  // first window would be cut short and raise a false fault.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      lf_prev_reg <= 1'b1;
    end else begin
      lf_prev_reg <= osc_lf_i;
    end
  end

  // The window spans two slow periods, so duty cycle does not
  // matter; a stopped oscillator is caught by the upper limit
  // even before the first edge is seen.
  // A glitch on osc_lf_i counts as an edge and can raise a fault,
  // so the pin is expected to be clean by the time it gets here.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      osc_state_reg <= OSC_SYNC;
      osc_cnt_reg   <= '0;
      osc_fail_reg  <= 1'b0;
    end else begin
      osc_fail_reg <= 1'b0;
      if (osc_late) begin
        osc_fail_reg  <= 1'b1;
        osc_cnt_reg   <= '0;
        osc_state_reg <= OSC_SYNC;
      end else begin
        osc_cnt_reg <= osc_cnt_reg + 1'b1;
        unique case (osc_state_reg)
          OSC_SYNC: begin
            if (lf_rise) begin
              osc_cnt_reg   <= '0;
              osc_state_reg <= OSC_ONE;
            end
          end
          OSC_ONE: begin
            if (lf_rise) begin
              osc_state_reg <= OSC_TWO;
            end
          end
          OSC_TWO: begin
            if (lf_rise) begin
              osc_fail_reg  <= (osc_cnt_reg < LO_LIM);
              osc_cnt_reg   <= '0;
              osc_state_reg <= OSC_ONE;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Diagnostic settling time check

  fasr_diag_t    diag_state_reg;
  logic [SW-1:0] diag_cnt_reg;
  logic          diag_short_reg;

  // A result that arrives before the settling time has passed may
  // be inaccurate, so it raises the die temperature alert.
  // A second start while one is running is ignored, so the time
  // is always counted from the first start of a measurement.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      diag_state_reg <= DG_IDLE;
      diag_cnt_reg   <= '0;
      diag_short_reg <= 1'b0;
    end else begin
      diag_short_reg <= 1'b0;
      unique case (diag_state_reg)
        DG_IDLE: begin
          if (cond_i.diag_start) begin
            diag_cnt_reg   <= '0;
            diag_state_reg <= DG_RUN;
          end
        end
        DG_RUN: begin
          if (diag_cnt_reg < ST_LIM) begin
            diag_cnt_reg <= diag_cnt_reg + 1'b1;
          end
          if (cond_i.diag_done) begin
            diag_short_reg <= (diag_cnt_reg < ST_LIM);
            diag_state_reg <= DG_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Power-on indicator

  logic por_flag_reg;

  // Only a zero in its bit of a status write clears the flag.
  // It never sets again outside reset, so the host can use it to
  // spot a reset that it did not ask for.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      por_flag_reg <= fasr_pkg::POR_FLAG_RST;
    end else if (wr_status && !wr_i.data[fasr_pkg::BIT_POR]) begin
      por_flag_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Set terms of the latched fault bits

  logic [15:0] set_vec;
  logic        armed;

  assign armed = ~por_flag_reg;

  // Supply and ground monitors are unreliable while the part is
  // still powering up, so they are held off until the host has
  // acknowledged the power-on event.
  always_comb begin
    set_vec = 16'h0000;
    set_vec[fasr_pkg::BIT_OSC1] = osc_fail_reg;
    set_vec[fasr_pkg::BIT_OSC2] = osc_fail_reg;
    set_vec[fasr_pkg::BIT_SEU1] = cond_i.upper_se & armed;
    set_vec[fasr_pkg::BIT_SEL1] = cond_i.lower_se & armed;
    set_vec[fasr_pkg::BIT_SEU2] = cond_i.upper_se;
    set_vec[fasr_pkg::BIT_SEL2] = cond_i.lower_se;
    set_vec[fasr_pkg::BIT_VDD1] = cond_i.supply_uv[0] & armed;
    set_vec[fasr_pkg::BIT_VDD2] = cond_i.supply_uv[1] & armed;
    set_vec[fasr_pkg::BIT_VDD3] = cond_i.supply_uv[2] & armed;
    set_vec[fasr_pkg::BIT_GND1] = cond_i.ground_open[0] & armed;
    set_vec[fasr_pkg::BIT_GND2] = cond_i.ground_open[1] & armed;
    set_vec[fasr_pkg::BIT_GND3] = cond_i.ground_open[2] & armed;
    set_vec[fasr_pkg::BIT_HVUV] = cond_i.hv_uv & armed;
    set_vec[fasr_pkg::BIT_TEMP] = cond_i.die_hot | diag_short_reg;
  end

  // ==========================================================
  // Latched fault bits

  logic [15:0] fault_reg;
  logic [15:0] fault_next;

  // Single-ended bits sit outside the clear mask and stay set
  // until reset, since the receiver mode is chosen only once.
  assign fault_next = (fault_reg & ~clr_vec) | set_vec;

  // The set term goes in after the clear, so a fault that is still
  // present while the host acknowledges it stays visible.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      fault_reg <= fasr_pkg::FAULT_RST;
    end else begin
      fault_reg <= fault_next;
    end
  end

  // ==========================================================
  // Read-only summaries

  logic [15:0] fault_view;
  logic [15:0] cell_view;
  logic [11:0] cell_or;

  // One bit per cell, built the same way for all twelve.
  for (genvar i = 0; i < fasr_pkg::CELLS; i++) begin : g_cell
    assign cell_or[i] = alert_i.cell_ov[i] | alert_i.cell_uv[i];
  end

  always_comb begin
    fault_view = fault_reg;
    fault_view[fasr_pkg::BIT_ZERO]  = 1'b0;
    fault_view[fasr_pkg::BIT_BALSW] = |alert_i.balsw;
  end

  always_comb begin
    cell_view = 16'h0000;
    cell_view[11:0] = cell_or;
    cell_view[fasr_pkg::BIT_AIN1] = alert_i.aux_ov[1]
                                  | alert_i.aux_uv[1];
    cell_view[fasr_pkg::BIT_AIN0] = alert_i.aux_ov[0]
                                  | alert_i.aux_uv[0];
  end

  // ==========================================================
  // Status outputs

  logic summary_reg;

  // Registered so the status owner sees a clean level; it lags
  // the fault bits by one cycle.
  // Bit 5 follows the balance-switch alerts live, so the summary
  // can rise without any latched fault being set.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      summary_reg <= 1'b0;
    end else begin
      summary_reg <= |fault_view;
    end
  end

  assign por_flag_o      = por_flag_reg;
  assign fault_summary_o = summary_reg;

  // ==========================================================
  // Read port

  logic [15:0] rd_data_reg;
  logic        rd_valid_reg;

  // Reads answer one cycle later; any other offset reads zero.
  // A read in the cycle of a write returns the value from before it.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rd_data_reg  <= 16'h0000;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_en_i;
      if (rd_en_i) begin
        if (fasr_hit(rd_addr_i, fasr_pkg::FAULT_OFS)) begin
          rd_data_reg <= fault_view;
        end else if (fasr_hit(rd_addr_i, fasr_pkg::CELL_OFS)) begin
          rd_data_reg <= cell_view;
        end else begin
          rd_data_reg <= 16'h0000;
        end
      end
    end
  end

  assign rd_data_o  = rd_data_reg;
  assign rd_valid_o = rd_valid_reg;

endmodule : fasr_regs

// >>> pkg/fasr_pkg.sv
// What this block does
// - Flag a fault when the slow oscillator is off by over five percent.
// - Re-evaluate the oscillator check every two slow-oscillator periods.
// - Bit 14 mirrors bit 15: same set condition, same clear.
// - Latched flags other than single-ended clear only by writing zero; writing one changes nothing.
// - Upper single-ended flag sets when upper receiver goes single-ended.
// - Lower single-ended flag sets when lower receiver goes single-ended.
// - Redundant single-ended flags set even while power-on flag is set.
// - Supply, ground, HV, primary SE flags wait for the power-on clear.
// - Each isolated ground pin open circuit latches its own flag.
// - High-voltage undervoltage latches bit 3; only a zero write clears.
// - Bit 5 reads as OR of all balance-switch alerts, read-only.
// - Die flag latches on overtemperature or too-short diagnostic settling.
// - Fault bit 13 and cell-alert bits 15 and 14 read zero.
// - Cell-alert bit 13 is OR of auxiliary input 1 alerts.
// - Cell-alert bit 12 is OR of auxiliary input 0 alerts.
// - Each cell bit is OR of that cell's over and under alerts.
// - Power-on flag sets on reset; host clears it by writing zero.
// - Summary bit is OR of all sixteen fault register bits.
package fasr_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] STATUS_OFS = 8'h02;
  localparam logic [7:0] FAULT_OFS  = 8'h03;
  localparam logic [7:0] CELL_OFS   = 8'h04;

  // ==========================================================
  // Field positions
  localparam int BIT_OSC1   = 15;
  localparam int BIT_OSC2   = 14;
  localparam int BIT_ZERO   = 13;
  localparam int BIT_SEU1   = 12;
  localparam int BIT_SEL1   = 11;
  localparam int BIT_SEU2   = 10;
  localparam int BIT_SEL2   = 9;
  localparam int BIT_VDD3   = 8;
  localparam int BIT_VDD2   = 7;
  localparam int BIT_GND2   = 6;
  localparam int BIT_BALSW  = 5;
  localparam int BIT_TEMP   = 4;
  localparam int BIT_HVUV   = 3;
  localparam int BIT_GND3   = 2;
  localparam int BIT_VDD1   = 1;
  localparam int BIT_GND1   = 0;
  localparam int BIT_AIN1   = 13;
  localparam int BIT_AIN0   = 12;
  localparam int BIT_POR    = 15;
  localparam int CELLS      = 12;

  // Bits that software clears by writing zero.
  localparam logic [15:0] FAULT_W0C_MASK = 16'hc1df;

  // ==========================================================
  // Reset values
  localparam logic [15:0] FAULT_RST    = 16'h0000;
  localparam logic        POR_FLAG_RST = 1'b1;

  // ==========================================================
  // Timing
  localparam int MCLK_HZ     = 200000000;
  localparam int OSC_NOM_HZ  = 32000;
  localparam int OSC_TOL_PCT = 5;
  localparam int OSC_SPAN    = MCLK_HZ / OSC_NOM_HZ * 2;
  localparam int OSC_LO_CYC  = OSC_SPAN * (100 - OSC_TOL_PCT) / 100;
  localparam int OSC_HI_CYC  = OSC_SPAN * (100 + OSC_TOL_PCT) / 100;
  localparam int SETTLE_US   = 50;
  localparam int SETTLE_CYC  = MCLK_HZ / 1000000 * SETTLE_US;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [15:0] data;
  } fasr_wr_t;

  typedef struct packed {
    logic       upper_se;
    logic       lower_se;
    logic [2:0] supply_uv;
    logic [2:0] ground_open;
    logic       hv_uv;
    logic       die_hot;
    logic       diag_start;
    logic       diag_done;
  } fasr_cond_t;

  typedef struct packed {
    logic [11:0] balsw;
    logic [11:0] cell_ov;
    logic [11:0] cell_uv;
    logic [1:0]  aux_ov;
    logic [1:0]  aux_uv;
  } fasr_alert_t;

endpackage : fasr_pkg
